//--- common/lcsf_pkg.sv
// constants, enumerations and widths of the connection service front end.
// assumes a single 10 MHz system clock and a synchronous reset.
package lcsf_pkg;
    localparam int CHAR_W = 8;
    localparam int BUF_CHARS = 4;
    localparam int CNT_W = 3;
    localparam int BUF_W = CHAR_W * BUF_CHARS;
    localparam int FIFO_W = BUF_W + CNT_W;
    localparam int FIFO_DEPTH = 4;
    localparam int SESSION_W = 8;
    localparam int LPORT_W = 4;
    localparam int RPORT_W = 8;
    localparam int CONN_W = 8;
    localparam logic [LPORT_W-1:0] LOCAL_PORT_ID = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_MAX = 3'h4;
    localparam logic [CONN_W-1:0] CONN_ID_RESET = 8'h01;
    localparam logic [CONN_W-1:0] CONN_ID_STEP = 8'h01;

    typedef enum logic [1:0] {
        idle_state,
        awaiting_peer_state,
        opening_state,
        linked_state
    } lcsf_state_t;

    typedef enum logic [1:0] {
        OP_LISTEN,
        OP_SEND,
        OP_DISCONNECT,
        OP_RESERVED
    } lcsf_op_t;

    typedef enum logic [3:0] {
        RSP_GOOD,
        RSP_INVALID_LOCAL_PORT,
        RSP_LOCAL_PORT_IN_USE,
        RSP_NO_PHYSICAL_CONNECTION,
        RSP_NOT_IN_ALLOWED_STATE,
        RSP_INVALID_CONNECTION,
        RSP_INVALID_BUFFER,
        RSP_OUT_OF_RESOURCES,
        RSP_NOT_CONNECTED
    } lcsf_rsp_t;
endpackage

//--- rtl/lcsf_fifo.sv
// small first-in first-out queue of send buffers, flip-flop storage.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module lcsf_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_reg != (AW+1)'(DEPTH));
        out_valid = (cnt_reg != '0);
        out_data = mem_reg[rd_reg];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
        rd_next = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage has no reset: nothing reads a slot before it is written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule // lcsf_fifo

//--- rtl/lcsf_tx_shift.sv
// unloads one queued buffer a character at a time onto the link.
// assumes the link takes a character when ready and valid are both high.
`timescale 1ns/100ps
module lcsf_tx_shift (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [lcsf_pkg::FIFO_W-1:0] in_data,
    output logic tx_valid,
    output logic [lcsf_pkg::CHAR_W-1:0] tx_char,
    input wire logic tx_ready,
    output logic done,
    output logic busy
);
    logic [lcsf_pkg::BUF_W-1:0] data_reg, data_next;
    logic [lcsf_pkg::CNT_W-1:0] left_reg, left_next;
    logic busy_reg, busy_next, done_reg, done_next;

    always_comb begin
        in_ready = !busy_reg;
        data_next = data_reg;
        left_next = left_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (!busy_reg && in_valid) begin
            data_next = in_data[lcsf_pkg::BUF_W-1:0];
            left_next = in_data[lcsf_pkg::FIFO_W-1:lcsf_pkg::BUF_W];
            busy_next = 1'b1;
        end else if (busy_reg && tx_ready) begin
            data_next = data_reg >> lcsf_pkg::CHAR_W;
            left_next = left_reg - lcsf_pkg::CNT_ONE;
            if (left_reg == lcsf_pkg::CNT_ONE) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_reg <= '0;
            left_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            left_reg <= left_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign tx_valid = busy_reg;
    assign tx_char = data_reg[lcsf_pkg::CHAR_W-1:0];
    assign done = done_reg;
    assign busy = busy_reg;
endmodule // lcsf_tx_shift

//--- rtl/lcsf_front.sv
// connection service front end: listen, send and disconnect requests.
// assumes requests synchronous to SYS_CLK, at most one per cycle.
`timescale 1ns/100ps

// Summary of operation
// R1: listen with remote port given accepts only that remote port
// R2: listen without remote port accepts any remote port
// R3: upper port issues listen only in the idle state
// R4: listen outside idle answers not-in-allowed-state
// R5: peer sense deasserted makes listen answer no-physical-connection
// R6: network port without ethernet signal answers no-physical-connection
// R7: serial port ignores the remote port argument of listen
// R8: unknown local port is invalid; busy local port is in use
// R9: connected only raised after a listen request
// R10: connected carries session, allocated connection id and remote port
// R11: upper port issues send only in the linked state
// R12: send outside linked state answers not-connected
// R13: earlier send buffers leave fully before later ones
// R14: send copies characters at acceptance
// R15: good send answer may precede transmission
// R16: send after disconnect answers invalid-connection
// R17: send naming a wrong connection answers invalid-connection
// R18: send with invalid buffer answers invalid-buffer
// R19: send with queue full answers out-of-resources
// R20: upper port supplies encoded characters and their count
// R21: sent means accepted; on serial port, means transmitted
// R22: disconnect drains all accepted characters before closing
// R23: states and answers are enumerations; one answer per request
module lcsf_front (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic NETWORK_VARIANT_PORT,
    input wire logic MEDIA_DRIVE_DEVICE,
    input wire logic SENSE_AUTOMATION,
    input wire logic SENSE_DRIVE,
    input wire logic ETH_SIGNAL,
    input wire logic REQ_VALID,
    input wire logic [1:0] REQ_OP,
    input wire logic [lcsf_pkg::SESSION_W-1:0] REQ_SESSION,
    input wire logic [lcsf_pkg::LPORT_W-1:0] REQ_LOCAL_PORT,
    input wire logic REQ_REMOTE_GIVEN,
    input wire logic [lcsf_pkg::RPORT_W-1:0] REQ_REMOTE_PORT,
    input wire logic [lcsf_pkg::CONN_W-1:0] REQ_CONN_ID,
    input wire logic REQ_BUF_OK,
    input wire logic [lcsf_pkg::CNT_W-1:0] REQ_SIZE,
    input wire logic [lcsf_pkg::BUF_W-1:0] REQ_DATA,
    output lcsf_pkg::lcsf_rsp_t RSP_CODE,
    output logic RSP_VALID,
    output logic CONNECTED,
    output logic [lcsf_pkg::SESSION_W-1:0] CONN_SESSION,
    output logic [lcsf_pkg::CONN_W-1:0] CONN_ID,
    output logic [lcsf_pkg::RPORT_W-1:0] CONN_REMOTE,
    output logic SENT,
    output logic DISCONNECTED,
    input wire logic PEER_OFFER,
    input wire logic [lcsf_pkg::RPORT_W-1:0] PEER_PORT,
    output logic PEER_ACCEPT,
    output logic PEER_REFUSE,
    output logic TX_VALID,
    output logic [lcsf_pkg::CHAR_W-1:0] TX_CHAR,
    input wire logic TX_READY,
    output lcsf_pkg::lcsf_state_t STATE
);
    lcsf_pkg::lcsf_state_t state_reg, state_next;
    lcsf_pkg::lcsf_rsp_t rsp_reg, rsp_next;
    lcsf_pkg::lcsf_op_t op;
    logic rsp_valid_reg, rsp_valid_next;
    logic conn_reg, conn_next, sent_reg, sent_next, disc_reg, disc_next;
    logic accept_reg, accept_next, refuse_reg, refuse_next;
    logic filter_reg, filter_next, closed_reg, closed_next;
    logic pending_reg, pending_next;
    logic [lcsf_pkg::SESSION_W-1:0] session_reg, session_next;
    logic [lcsf_pkg::CONN_W-1:0] id_reg, id_next;
    logic [lcsf_pkg::RPORT_W-1:0] fport_reg, fport_next;
    logic [lcsf_pkg::RPORT_W-1:0] remote_reg, remote_next;
    logic presence, push, fifo_in_ready, q_valid, q_ready, tx_done, tx_busy;
    logic buf_ok, id_ok;
    logic [lcsf_pkg::FIFO_W-1:0] q_data;

    // characters are copied into the queue when the send is taken
    lcsf_fifo #(
        .WIDTH(lcsf_pkg::FIFO_W),
        .DEPTH(lcsf_pkg::FIFO_DEPTH)
    ) u_queue (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({REQ_SIZE, REQ_DATA}), // see R14
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    lcsf_tx_shift u_shift (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .in_valid(q_valid), // see R13
        .in_ready(q_ready),
        .in_data(q_data),
        .tx_valid(TX_VALID),
        .tx_char(TX_CHAR),
        .tx_ready(TX_READY),
        .done(tx_done),
        .busy(tx_busy)
    );

    always_comb begin
        op = lcsf_pkg::lcsf_op_t'(REQ_OP);
        // a drive watches the automation sense, automation the drive sense
        presence = NETWORK_VARIANT_PORT ? ETH_SIGNAL : // see R6
            (MEDIA_DRIVE_DEVICE ? SENSE_AUTOMATION : SENSE_DRIVE); // see R5
        buf_ok = REQ_BUF_OK && (REQ_SIZE != '0) &&
            (REQ_SIZE <= lcsf_pkg::CNT_MAX);
        id_ok = (REQ_CONN_ID == id_reg);
        state_next = state_reg;
        rsp_next = rsp_reg;
        rsp_valid_next = 1'b0;
        conn_next = 1'b0;
        sent_next = !NETWORK_VARIANT_PORT && tx_done; // see R21
        disc_next = 1'b0;
        accept_next = 1'b0;
        refuse_next = 1'b0;
        filter_next = filter_reg;
        fport_next = fport_reg;
        closed_next = closed_reg;
        pending_next = pending_reg;
        session_next = session_reg;
        id_next = id_reg;
        remote_next = remote_reg;
        push = 1'b0;
        case (state_reg)
            lcsf_pkg::awaiting_peer_state: begin
                if (!NETWORK_VARIANT_PORT) begin
                    // serial link connects as soon as sense is seen; losing sense later does not drop it
                    if (presence) begin
                        state_next = lcsf_pkg::linked_state; // see R9
                        conn_next = 1'b1;
                        id_next = id_reg + lcsf_pkg::CONN_ID_STEP; // see R10
                        remote_next = '0;
                    end
                end else if (PEER_OFFER) begin
                    if (!filter_reg || PEER_PORT == fport_reg) begin // see R2
                        state_next = lcsf_pkg::linked_state; // see R9
                        accept_next = 1'b1;
                        conn_next = 1'b1;
                        id_next = id_reg + lcsf_pkg::CONN_ID_STEP; // see R10
                        remote_next = PEER_PORT; // see R10
                    end else begin
                        refuse_next = 1'b1; // see R1
                    end
                end
            end
            default: begin
            end
        endcase
        if (REQ_VALID) begin
            rsp_valid_next = 1'b1; // see R23
            case (op)
                lcsf_pkg::OP_LISTEN: begin
                    if (state_reg != lcsf_pkg::idle_state) begin
                        rsp_next = lcsf_pkg::RSP_NOT_IN_ALLOWED_STATE; // see R4
                    end else if (REQ_LOCAL_PORT != lcsf_pkg::LOCAL_PORT_ID) begin
                        rsp_next = lcsf_pkg::RSP_INVALID_LOCAL_PORT; // see R8
                    end else if (pending_reg) begin
                        // the single connection is still draining
                        rsp_next = lcsf_pkg::RSP_LOCAL_PORT_IN_USE; // see R8
                    end else if (!presence) begin
                        rsp_next = lcsf_pkg::RSP_NO_PHYSICAL_CONNECTION; // see R5
                    end else begin
                        rsp_next = lcsf_pkg::RSP_GOOD;
                        state_next = lcsf_pkg::awaiting_peer_state;
                        session_next = REQ_SESSION;
                        closed_next = 1'b0;
                        // serial ports drop the filter altogether
                        filter_next = REQ_REMOTE_GIVEN &&
                            NETWORK_VARIANT_PORT; // see R7
                        fport_next = REQ_REMOTE_PORT; // see R1
                    end
                end
                lcsf_pkg::OP_SEND: begin
                    if (closed_reg) begin
                        rsp_next = lcsf_pkg::RSP_INVALID_CONNECTION; // see R16
                    end else if (state_reg != lcsf_pkg::linked_state) begin
                        rsp_next = lcsf_pkg::RSP_NOT_CONNECTED; // see R12
                    end else if (!id_ok) begin
                        rsp_next = lcsf_pkg::RSP_INVALID_CONNECTION; // see R17
                    end else if (!buf_ok) begin
                        rsp_next = lcsf_pkg::RSP_INVALID_BUFFER; // see R18
                    end else if (!fifo_in_ready) begin
                        rsp_next = lcsf_pkg::RSP_OUT_OF_RESOURCES; // see R19
                    end else begin
                        // good answer before the characters leave
                        rsp_next = lcsf_pkg::RSP_GOOD; // see R15
                        push = 1'b1; // see R14
                        // a serial buffer finishing now must still report
                        sent_next = sent_next ||
                            NETWORK_VARIANT_PORT; // see R21
                    end
                end
                lcsf_pkg::OP_DISCONNECT: begin
                    if (state_reg == lcsf_pkg::idle_state) begin
                        rsp_next = lcsf_pkg::RSP_NOT_IN_ALLOWED_STATE;
                    end else if (state_reg == lcsf_pkg::linked_state &&
                                 !id_ok) begin
                        rsp_next = lcsf_pkg::RSP_INVALID_CONNECTION;
                    end else begin
                        rsp_next = lcsf_pkg::RSP_GOOD;
                        state_next = lcsf_pkg::idle_state;
                        conn_next = 1'b0;
                        accept_next = 1'b0;
                        closed_next = (state_reg ==
                            lcsf_pkg::linked_state); // see R16
                        pending_next = 1'b1; // see R22
                    end
                end
                default: begin
                    rsp_next = lcsf_pkg::RSP_NOT_IN_ALLOWED_STATE;
                end
            endcase
        end
        // close is announced only once queue and shifter are empty
        if (pending_reg && !q_valid && !tx_busy) begin
            pending_next = 1'b0;
            disc_next = 1'b1; // see R22
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state_reg <= lcsf_pkg::idle_state;
            rsp_reg <= lcsf_pkg::RSP_GOOD;
            rsp_valid_reg <= 1'b0;
            conn_reg <= 1'b0;
            sent_reg <= 1'b0;
            disc_reg <= 1'b0;
            accept_reg <= 1'b0;
            refuse_reg <= 1'b0;
            filter_reg <= 1'b0;
            fport_reg <= '0;
            closed_reg <= 1'b0;
            pending_reg <= 1'b0;
            session_reg <= '0;
            id_reg <= lcsf_pkg::CONN_ID_RESET;
            remote_reg <= '0;
        end else begin
            state_reg <= state_next;
            rsp_reg <= rsp_next;
            rsp_valid_reg <= rsp_valid_next;
            conn_reg <= conn_next;
            sent_reg <= sent_next;
            disc_reg <= disc_next;
            accept_reg <= accept_next;
            refuse_reg <= refuse_next;
            filter_reg <= filter_next;
            fport_reg <= fport_next;
            closed_reg <= closed_next;
            pending_reg <= pending_next;
            session_reg <= session_next;
            id_reg <= id_next;
            remote_reg <= remote_next;
        end
    end

    assign RSP_CODE = rsp_reg;
    assign RSP_VALID = rsp_valid_reg;
    assign CONNECTED = conn_reg;
    assign CONN_SESSION = session_reg;
    assign CONN_ID = id_reg;
    assign CONN_REMOTE = remote_reg;
    assign SENT = sent_reg;
    assign DISCONNECTED = disc_reg;
    assign PEER_ACCEPT = accept_reg;
    assign PEER_REFUSE = refuse_reg;
    assign STATE = state_reg;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_listen_idle_ok;
        REQ_VALID && REQ_OP == lcsf_pkg::OP_LISTEN &&
        state_reg == lcsf_pkg::idle_state &&
        REQ_LOCAL_PORT == lcsf_pkg::LOCAL_PORT_ID && !pending_reg;
    endsequence
    sequence s_offer_alone;
        state_reg == lcsf_pkg::awaiting_peer_state && NETWORK_VARIANT_PORT &&
        PEER_OFFER && !REQ_VALID;
    endsequence

    a_listen_wrong_state: assert property ( // see R4
        REQ_VALID && REQ_OP == lcsf_pkg::OP_LISTEN &&
        state_reg != lcsf_pkg::idle_state |=>
        RSP_VALID && RSP_CODE == lcsf_pkg::RSP_NOT_IN_ALLOWED_STATE)
        else $error("listen outside idle not refused");
    a_listen_no_peer: assert property ( // see R6
        s_listen_idle_ok and !presence |=>
        RSP_CODE == lcsf_pkg::RSP_NO_PHYSICAL_CONNECTION &&
        STATE == lcsf_pkg::idle_state)
        else $error("listen without presence not refused");
    a_filter_refuse: assert property ( // see R1
        s_offer_alone and filter_reg && PEER_PORT != fport_reg |=>
        PEER_REFUSE && !CONNECTED ##1 STATE == lcsf_pkg::awaiting_peer_state)
        else $error("offer from foreign port accepted");
    a_open_accept: assert property ( // see R2
        s_offer_alone and !filter_reg |=>
        CONNECTED && PEER_ACCEPT && CONN_REMOTE == $past(PEER_PORT))
        else $error("open listen did not accept");
    a_conn_origin: assert property ( // see R9
        $rose(CONNECTED) |->
        $past(state_reg) == lcsf_pkg::awaiting_peer_state &&
        CONN_ID == $past(id_reg) + lcsf_pkg::CONN_ID_STEP)
        else $error("connected without listen");
    a_send_unlinked: assert property ( // see R12
        REQ_VALID && REQ_OP == lcsf_pkg::OP_SEND && !closed_reg &&
        state_reg != lcsf_pkg::linked_state |=>
        RSP_CODE == lcsf_pkg::RSP_NOT_CONNECTED && !SENT)
        else $error("send outside linked not refused");
    a_send_closed: assert property ( // see R16
        REQ_VALID && REQ_OP == lcsf_pkg::OP_SEND && closed_reg |=>
        RSP_CODE == lcsf_pkg::RSP_INVALID_CONNECTION)
        else $error("send after disconnect not refused");
    a_queue_full: assert property ( // see R19
        REQ_VALID && REQ_OP == lcsf_pkg::OP_SEND && !closed_reg &&
        state_reg == lcsf_pkg::linked_state && id_ok && buf_ok &&
        !fifo_in_ready |=> RSP_CODE == lcsf_pkg::RSP_OUT_OF_RESOURCES)
        else $error("full queue not reported");
    a_one_answer: assert property ( // see R23
        REQ_VALID |=> RSP_VALID) else $error("request without answer");
    a_drain_close: assert property ( // see R22
        DISCONNECTED |-> !$past(q_valid) && !$past(tx_busy) && !TX_VALID)
        else $error("closed before drain");
    a_serial_sent: assert property ( // see R21
        !NETWORK_VARIANT_PORT && SENT |-> $past(tx_done))
        else $error("serial sent before transmission");
endmodule // lcsf_front

//--- test/lcsf_link_sink.sv
// link receiver model standing at the far side of the transmit port.
// assumes one clock; ready alternates so answers come promptly and slowly.
`timescale 1ns/100ps
module lcsf_link_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic slow_reg;
    // ready only changes after an edge, so a taken character is unambiguous
    assign tx_ready = ~stall & slow_reg;
    always @(posedge clk) begin
        if (rst)
            slow_reg <= 1'b0;
        else
            slow_reg <= ~slow_reg;
        if (!rst && tx_valid && tx_ready)
            got.push_back(tx_char);
    end
endmodule // lcsf_link_sink

//--- test/testbench.sv
// self-checking bench of the connection service front end.
// assumes the link sink model; serial variant first, then network.
`timescale 1ns/100ps
module testbench;
    logic clk = 0, rst = 1, net = 0, sense = 0, eth = 0, stall = 0;
    logic mdd = 1, sdrv = 0;
    logic rv = 0, rg = 0, bok = 1, offer = 0, tx_valid, tx_ready;
    logic [1:0] op = 2'h0;
    logic [3:0] lport = 4'h0;
    logic [7:0] rport = 8'h00, cid = 8'h00, pport = 8'h00, tx_char;
    logic [2:0] sz = 3'h1;
    logic [31:0] dat = 32'h0;
    logic rsp_valid, connected, sent, disc, accept, refuse;
    logic [7:0] c_sess, c_id, c_rem;
    lcsf_pkg::lcsf_rsp_t rsp_code;
    lcsf_pkg::lcsf_state_t state;
    int n_errors = 0, checked = 0, cyc = 0, n_disc = 0, n_sent = 0, i;

    always #50 clk = ~clk;

    lcsf_front DUT (.SYS_CLK(clk), .SYS_RST(rst),
        .NETWORK_VARIANT_PORT(net), .MEDIA_DRIVE_DEVICE(mdd),
        .SENSE_AUTOMATION(sense), .SENSE_DRIVE(sdrv), .ETH_SIGNAL(eth),
        .REQ_VALID(rv), .REQ_OP(op), .REQ_SESSION(8'h5A),
        .REQ_LOCAL_PORT(lport), .REQ_REMOTE_GIVEN(rg),
        .REQ_REMOTE_PORT(rport), .REQ_CONN_ID(cid), .REQ_BUF_OK(bok),
        .REQ_SIZE(sz), .REQ_DATA(dat), .RSP_CODE(rsp_code),
        .RSP_VALID(rsp_valid), .CONNECTED(connected),
        .CONN_SESSION(c_sess), .CONN_ID(c_id), .CONN_REMOTE(c_rem),
        .SENT(sent), .DISCONNECTED(disc), .PEER_OFFER(offer),
        .PEER_PORT(pport), .PEER_ACCEPT(accept), .PEER_REFUSE(refuse),
        .TX_VALID(tx_valid), .TX_CHAR(tx_char), .TX_READY(tx_ready),
        .STATE(state));

    lcsf_link_sink sink (.clk(clk), .rst(rst), .stall(stall),
        .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready));

    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cyc++;
        if (disc)
            n_disc++;
        if (sent)
            n_sent++;
        if (cyc == 4000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1 chk("state", 0, state);
        chk("rsp_code", 0, rsp_code);
        chk("conn_id", 1, c_id);
    endtask

    // one request, answer looked at in its single valid cycle
    task automatic rq(input logic [1:0] o, input logic [3:0] exp);
        @(posedge clk);
        rv <= 1'b1;
        op <= o;
        @(posedge clk);
        rv <= 1'b0;
        #1 chk("rsp_valid", 1, rsp_valid);
        chk("rsp_code", exp, rsp_code);
    endtask

    task automatic peer(input logic [7:0] p, input logic ok);
        @(posedge clk);
        offer <= 1'b1;
        pport <= p;
        @(posedge clk);
        offer <= 1'b0;
        #1 chk("peer_accept", ok, accept);
        chk("peer_refuse", !ok, refuse);
        chk("connected", ok, connected);
    endtask

    task automatic wait_chars(input int n);
        for (i = 0; i < 300 && sink.got.size() < n; i++)
            @(posedge clk);
        chk("char_count", n, sink.got.size());
    endtask

    task automatic t_listen_serial();
        rq(2'h1, 4'h8);
        rq(2'h3, 4'h4);
        lport <= 4'h3;
        rq(2'h0, 4'h1);
        lport <= 4'h0;
        rq(2'h0, 4'h3);
        mdd <= 1'b0;
        sense <= 1'b1;
        rq(2'h0, 4'h3);
        sdrv <= 1'b1;
        rg <= 1'b1;
        rport <= 8'h77;
        rq(2'h0, 4'h0);
        @(posedge clk);
        #1 chk("connected", 1, connected);
        chk("conn_id", 2, c_id);
        chk("conn_session", 8'h5A, c_sess);
        chk("conn_remote", 0, c_rem);
        chk("state", 3, state);
        rq(2'h0, 4'h4);
    endtask

    task automatic t_send_serial();
        cid <= 8'h09;
        rq(2'h1, 4'h5);
        cid <= 8'h02;
        bok <= 1'b0;
        rq(2'h1, 4'h6);
        bok <= 1'b1;
        sz <= 3'h2;
        dat <= 32'h0000B2A1;
        rq(2'h1, 4'h0);
        sz <= 3'h3;
        dat <= 32'h00C3C2C1;
        rq(2'h1, 4'h0);
        dat <= 32'hFFFFFFFF;
        wait_chars(5);
        repeat (3) @(posedge clk);
        chk("sent_count", 2, n_sent);
        chk("chars", 40'hA1B2C1C2C3, {sink.got[0], sink.got[1],
            sink.got[2], sink.got[3], sink.got[4]});
        stall <= 1'b1;
        sz <= 3'h1;
        dat <= 32'h000000D0;
        rq(2'h1, 4'h0);
        #1 chk("sent", 0, sent);
        for (int k = 0; k < 4; k++)
            rq(2'h1, 4'h0);
        rq(2'h1, 4'h7);
    endtask

    task automatic t_disconnect();
        rq(2'h2, 4'h0);
        chk("state", 0, state);
        rq(2'h1, 4'h5);
        rq(2'h0, 4'h2);
        chk("disc_early", 0, n_disc);
        stall <= 1'b0;
        wait_chars(10);
        for (i = 0; i < 50 && n_disc == 0; i++)
            @(posedge clk);
        chk("disc_count", 1, n_disc);
        chk("sent_count", 7, n_sent);
    endtask

    task automatic t_network();
        net <= 1'b1;
        do_reset();
        rq(2'h0, 4'h3);
        eth <= 1'b1;
        rport <= 8'h22;
        rq(2'h0, 4'h0);
        chk("state", 1, state);
        peer(8'h33, 1'b0);
        peer(8'h22, 1'b1);
        chk("conn_remote", 8'h22, c_rem);
        rq(2'h1, 4'h0);
        chk("sent", 1, sent);
        rq(2'h2, 4'h0);
        for (i = 0; i < 50 && n_disc < 2; i++)
            @(posedge clk);
        chk("disc_count", 2, n_disc);
        rg <= 1'b0;
        rq(2'h0, 4'h0);
        peer(8'h5B, 1'b1);
    endtask

    initial begin
        do_reset();
        t_listen_serial();
        t_send_serial();
        t_disconnect();
        t_network();
        close_out();
    end
endmodule // testbench
